//--- pkg/pwdc_consts.svh
// Constants of the pulse width delay control block.
// Assumes inclusion by bare name before use.
`ifndef PWDC_CONSTS_SVH
`define PWDC_CONSTS_SVH
// Register offsets on the plain register port.
`define PWDC_A_SEL 4'h0
`define PWDC_A_DATA 4'h1
`define PWDC_A_OFS 4'h2
`define PWDC_A_PANEL 4'h3
`define PWDC_A_CTRL 4'h4
`define PWDC_A_STAT 4'h5
`define PWDC_A_TOTAL 4'h6
`define PWDC_A_DISP 4'h7
// Field positions.
`define PWDC_SEL_EN 4
`define PWDC_OFS_BYP 10
`define PWDC_OFS_FADE 11
`define PWDC_OFS_MUTE 12
`define PWDC_CTRL_COMP 0
`define PWDC_CTRL_BYP 1
`define PWDC_CTRL_MS 2
// Decoder select codes.
`define PWDC_SEL_PANEL 4'h4
`define PWDC_SEL_OFS 4'h5
`define PWDC_SEL_JMP 4'h6
`define PWDC_SEL_FRM 4'h7
`define PWDC_SEL_PHY 4'h8
`define PWDC_SEL_CNT_A 4'h9
`define PWDC_SEL_CNT_B 4'hA
// Reset values.
`define PWDC_CTRL_RST 3'h0
`define PWDC_OFS_RST 13'h0000
// Timing.
`define PWDC_CLK_NS 5
`define PWDC_TICK_NS 19530
`define PWDC_TICK_CYC (`PWDC_TICK_NS / `PWDC_CLK_NS)
`define PWDC_TICK_10NS (`PWDC_TICK_NS / 10)
`define PWDC_TIMEOUT_US 1000000
`define PWDC_TIMEOUT_TICKS (`PWDC_TIMEOUT_US * 1000 / `PWDC_TICK_NS)
`define PWDC_CNT_MAX 12'hFFF
`define PWDC_FRAME_MS 40
`endif

//--- pkg/pwdc_pkg.sv
// Types of the pulse width delay control block.
// Assumes nothing of its surroundings.
package pwdc_pkg;
  typedef enum logic [1:0] {
    pwdc_st_idle = 2'b00,
    pwdc_st_count = 2'b01,
    pwdc_st_end = 2'b11
  } pwdc_meas_t;
  typedef struct packed {
    pwdc_meas_t st;
    logic [11:0] cnt;
    logic [11:0] tick_cnt;
    logic eop1;
    logic eop2;
    logic [11:0] latch;
    logic irq;
    logic ovf;
    logic [15:0] tmo_cnt;
    logic tmo;
    logic [3:0] sel;
    logic sel_en;
    logic [12:0] ofs_stage;
    logic [12:0] ofs_latch;
    logic [7:0] panel;
    logic [2:0] ctrl;
    logic [31:0] rdata;
  } pwdc_state_t;
  typedef struct packed {
    logic [11:0] acc;
    logic valid;
    logic [31:0] total;
    logic [15:0] disp;
  } pwdc_calc_t;
endpackage : pwdc_pkg

//--- hw/pwdc_delay_calc.sv
// Delay calculation: accepted width, hysteresis, total delay.
// Assumes one clock and a one-cycle capture pulse from the measurer.
`timescale 1ns/1ps
`include "pwdc_consts.svh"
module pwdc_delay_calc (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic capture_in,
  input wire logic [11:0] count_in,
  input wire logic timeout_in,
  input wire logic [3:0] hyst_sel_in,
  input wire logic comp_en_in,
  input wire logic bypass_in,
  input wire logic unit_ms_in,
  input wire logic [15:0] base_bcd_in,
  output logic [31:0] total_out,
  output logic [15:0] display_out
);
  import pwdc_pkg::*;
  // Hysteresis window in microseconds per switch position.
  function automatic logic [11:0] hyst_us(input logic [3:0] p);
    unique case (p)
      4'h0: hyst_us = 12'h014;
      4'h1: hyst_us = 12'h027;
      4'h2: hyst_us = 12'h04E;
      4'h3: hyst_us = 12'h075;
      4'h4: hyst_us = 12'h09C;
      4'h5: hyst_us = 12'h0C3;
      4'h6: hyst_us = 12'h138;
      4'h7: hyst_us = 12'h270;
      4'h8: hyst_us = 12'h4E0;
      4'h9: hyst_us = 12'h9C0;
      default: hyst_us = 12'h9C0;
    endcase
  endfunction : hyst_us
  // Four decimal digits to binary milliseconds.
  function automatic logic [13:0] bcd_ms(input logic [15:0] b);
    bcd_ms = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
  endfunction : bcd_ms
  pwdc_calc_t s, n;
  logic [11:0] diff;
  logic [31:0] comp, base, ms;
  // Accept the first width, later ones only outside the window, then sum the delay.
  always_comb begin
    n = s;
    diff = (count_in > s.acc) ? 12'(count_in - s.acc) : 12'(s.acc - count_in);
    if (timeout_in) begin
      n.acc = `PWDC_CNT_MAX;
      n.valid = 1'b1;
    end else if (capture_in && (!s.valid || 32'(diff) * `PWDC_TICK_10NS > 32'(hyst_us(hyst_sel_in)) * 100)) begin
      n.acc = count_in;
      n.valid = 1'b1;
    end
    comp = 32'(s.acc) * `PWDC_TICK_10NS;
    base = 32'(bcd_ms(base_bcd_in)) * 100000;
    if (bypass_in) begin
      n.total = 32'h0;
    end else if (comp_en_in) begin
      n.total = base + comp;
    end else begin
      n.total = base;
    end
    ms = s.total / 100000;
    n.disp = unit_ms_in ? 16'(ms) : 16'(ms / `PWDC_FRAME_MS);
  end
  // State register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign total_out = s.total;
  assign display_out = s.disp;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_bypass_zero: assert property (bypass_in |=> total_out == 32'h0)
    else $error("bypass did not zero the delay");
  a_comp_off: assert property (!bypass_in && !comp_en_in
    |=> total_out == 32'(bcd_ms($past(base_bcd_in))) * 100000)
    else $error("base only delay wrong");
  a_timeout_max: assert property (timeout_in |=> s.acc == `PWDC_CNT_MAX)
    else $error("timeout did not force maximum");
endmodule : pwdc_delay_calc

//--- hw/pwdc_pulse_width_ctrl.sv
// Pulse width measurement, select decoder and offset latch.
// Assumes synchronous inputs, static jumpers and a 200 MHz clock.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pwdc_consts.svh"
module pwdc_pulse_width_ctrl #(
  parameter int unsigned TIMEOUT_TICKS = `PWDC_TIMEOUT_TICKS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic pulse_in,
  input wire logic active_low_jumper_in,
  input wire logic active_high_jumper_in,
  input wire logic [15:0] base_digits_in,
  input wire logic [7:0] toggle_sw_in,
  input wire logic [7:0] jumpers_in,
  input wire logic [7:0] frame_hyst_in,
  input wire logic [3:0] pulse_hyst_in,
  output logic irq_out,
  output logic digit0_select_out,
  output logic digit1_select_out,
  output logic digit2_select_out,
  output logic digit3_select_out,
  output logic panel_led_switch_select_out,
  output logic offset_word_select_out,
  output logic jumper_read_select_out,
  output logic frame_hyst_read_select_out,
  output logic pulse_hyst_read_select_out,
  output logic count_read_select_a_out,
  output logic count_read_select_b_out,
  output logic [7:0] panel_out,
  output logic [9:0] offset_out,
  output logic bypass_out,
  output logic fade_out,
  output logic mute_out,
  output logic [31:0] total_delay_out,
  output logic [15:0] display_out
);
  import pwdc_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************

  pwdc_state_t s, n;
  logic active;
  logic active_high;
  logic tick;
  logic capture;
  logic count_clear;
  logic [10:0] sel_vec;
  logic [12:0] cnt_sum;

  // Read data of the function select decoder.
  function automatic logic [31:0] sel_data(
    input logic [3:0] sel,
    input logic [15:0] digits,
    input logic [7:0] toggles,
    input logic [7:0] jumpers,
    input logic [7:0] frame_h,
    input logic pres,
    input logic [3:0] pulse_h,
    input logic [11:0] latch
  );
    sel_data = 32'h0;
    unique case (sel)
      4'h0, 4'h1, 4'h2, 4'h3: sel_data = 32'(digits[{sel[1:0], 2'b00} +: 4]);
      `PWDC_SEL_PANEL: sel_data = 32'(toggles);
      `PWDC_SEL_JMP: sel_data = 32'(jumpers);
      `PWDC_SEL_FRM: sel_data = 32'(frame_h);
      `PWDC_SEL_PHY: sel_data = 32'({pres, pulse_h});
      `PWDC_SEL_CNT_A: sel_data = 32'(latch[7:0]);
      `PWDC_SEL_CNT_B: sel_data = 32'(latch[11:8]);
      default: sel_data = 32'h0;
    endcase
  endfunction : sel_data

  // ************************************************************
  // Input polarity and reference tick
  // ************************************************************

  // The level that counts as active follows the jumpers.
  assign active_high = active_high_jumper_in & ~active_low_jumper_in;
  assign active = active_high ? pulse_in : ~pulse_in;
  assign tick = (s.tick_cnt == 12'(`PWDC_TICK_CYC - 1));
  assign cnt_sum = {1'b0, s.cnt} + 13'h0001;

  // Latch the count once the second flag stands and no request is pending.
  assign capture = s.eop2 && !s.irq;

  // A read of the upper count nibble ends the measurement.
  assign count_clear = rd_in && (addr_in == `PWDC_A_DATA) && s.sel_en &&
                       (s.sel == `PWDC_SEL_CNT_B) && s.irq;

  // One-hot decoder selects.
  assign sel_vec = s.sel_en ? (11'h001 << s.sel) : 11'h000;

  // ************************************************************
  // Next state
  // ************************************************************

  // Measurement sequence, timeout and register access.
  always_comb begin
    n = s;
    n.rdata = 32'h0;
    n.tick_cnt = tick ? 12'h000 : 12'(s.tick_cnt + 12'h001);
    unique case (s.st)
      pwdc_st_idle: begin
        if (active) begin
          n.st = pwdc_st_count;
        end
      end
      pwdc_st_count: begin
        if (!active) begin
          n.st = pwdc_st_end;
          n.eop1 = 1'b1;
        end else if (tick) begin
          n.cnt = cnt_sum[11:0];
          if (cnt_sum[12]) begin
            n.ovf = 1'b1;
          end
        end
      end
      pwdc_st_end: begin
        if (tick) begin
          n.eop2 = s.eop1;
        end
      end
    endcase
    if (capture) begin
      n.latch = s.cnt;
      n.irq = 1'b1;
    end
    // Long active level: count ticks toward the one second limit.
    if (!active) begin
      n.tmo_cnt = 16'h0000;
      n.tmo = 1'b0;
    end else if (tick && !s.tmo) begin
      if (32'(s.tmo_cnt) == TIMEOUT_TICKS - 1) begin
        n.tmo = 1'b1;
      end else begin
        n.tmo_cnt = 16'(s.tmo_cnt + 16'h0001);
      end
    end
    // Offset word moves to the latch while its select stands.
    if (sel_vec[`PWDC_SEL_OFS]) begin
      n.ofs_latch = s.ofs_stage;
    end
    if (wr_in) begin
      unique case (addr_in)
        `PWDC_A_SEL: begin
          n.sel = wr_data_in[3:0];
          n.sel_en = wr_data_in[`PWDC_SEL_EN];
        end
        `PWDC_A_OFS: n.ofs_stage = wr_data_in[12:0];
        `PWDC_A_PANEL: n.panel = wr_data_in[7:0];
        `PWDC_A_CTRL: n.ctrl = wr_data_in[2:0];
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        `PWDC_A_SEL: n.rdata = 32'({s.sel_en, s.sel});
        `PWDC_A_DATA: begin
          if (s.sel_en) begin
            n.rdata = sel_data(s.sel, base_digits_in, toggle_sw_in, jumpers_in,
                               frame_hyst_in, active, pulse_hyst_in, s.latch);
          end
        end
        `PWDC_A_OFS: n.rdata = 32'(s.ofs_stage);
        `PWDC_A_PANEL: n.rdata = 32'(s.panel);
        `PWDC_A_CTRL: n.rdata = 32'(s.ctrl);
        `PWDC_A_STAT: n.rdata = 32'({active, s.tmo, s.ovf, s.irq, s.eop2, s.eop1});
        `PWDC_A_TOTAL: n.rdata = total_delay_out;
        `PWDC_A_DISP: n.rdata = 32'(display_out);
        default: n.rdata = 32'h0;
      endcase
    end
    if (count_clear) begin
      n.eop1 = 1'b0;
      n.eop2 = 1'b0;
      n.cnt = 12'h000;
      n.irq = 1'b0;
      n.ovf = 1'b0;
      n.st = pwdc_st_idle;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // All state lives in one struct.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.st <= pwdc_st_idle;
      s.ctrl <= `PWDC_CTRL_RST;
      s.ofs_stage <= `PWDC_OFS_RST;
      s.ofs_latch <= `PWDC_OFS_RST;
    end else begin
      s <= n;
    end
  end

  // ************************************************************
  // Delay calculation
  // ************************************************************

  // Turns the latched width into the total delay.
  pwdc_delay_calc u_calc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .capture_in(capture),
    .count_in(s.cnt),
    .timeout_in(s.tmo),
    .hyst_sel_in(pulse_hyst_in),
    .comp_en_in(s.ctrl[`PWDC_CTRL_COMP]),
    .bypass_in(s.ctrl[`PWDC_CTRL_BYP]),
    .unit_ms_in(s.ctrl[`PWDC_CTRL_MS]),
    .base_bcd_in(base_digits_in),
    .total_out(total_delay_out),
    .display_out(display_out)
  );

  // ************************************************************
  // Outputs
  // ************************************************************

  // Decoder selects, panel data, offset latch and read data.
  assign digit0_select_out = sel_vec[0];
  assign digit1_select_out = sel_vec[1];
  assign digit2_select_out = sel_vec[2];
  assign digit3_select_out = sel_vec[3];
  assign panel_led_switch_select_out = sel_vec[4];
  assign offset_word_select_out = sel_vec[5];
  assign jumper_read_select_out = sel_vec[6];
  assign frame_hyst_read_select_out = sel_vec[7];
  assign pulse_hyst_read_select_out = sel_vec[8];
  assign count_read_select_a_out = sel_vec[9];
  assign count_read_select_b_out = sel_vec[10];
  assign panel_out = s.panel;
  assign offset_out = s.ofs_latch[9:0];
  assign bypass_out = s.ofs_latch[`PWDC_OFS_BYP];
  assign fade_out = s.ofs_latch[`PWDC_OFS_FADE];
  assign mute_out = s.ofs_latch[`PWDC_OFS_MUTE];
  assign irq_out = s.irq;
  assign rd_data_out = s.rdata;

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_start_count: assert property (s.st == pwdc_st_idle && active && !count_clear |=> s.st == pwdc_st_count)
    else $error("active level did not start counting");
  a_trail_stop: assert property (s.st == pwdc_st_count && !active |=> s.eop1 && $stable(s.cnt))
    else $error("trailing edge did not stop the counter");
  a_eop_sync: assert property ($rose(s.eop2) |-> $past(s.eop1) && $past(tick))
    else $error("second flag rose without first flag");
  a_latch_irq: assert property (capture |=> irq_out && s.latch == $past(s.cnt))
    else $error("count not latched with request");
  a_read_clear: assert property (count_clear |=> !s.eop1 && !s.eop2 && s.cnt == 12'h000 && !irq_out)
    else $error("count read did not clear");
  a_tick_space: assert property (tick |=> !tick [*8])
    else $error("reference ticks too close");
  a_count_wrap: assert property (s.st == pwdc_st_count && active && tick && s.cnt == `PWDC_CNT_MAX
    |=> s.cnt == 12'h000 && s.ovf)
    else $error("counter wrap not flagged");
  a_sel_onehot: assert property ($onehot0(sel_vec))
    else $error("more than one decoder select");
  a_ofs_load: assert property (offset_word_select_out |=> s.ofs_latch == $past(s.ofs_stage))
    else $error("offset latch not loaded");
  a_cnt_low: assert property (rd_in && addr_in == `PWDC_A_DATA && count_read_select_a_out
    |=> rd_data_out == 32'($past(s.latch[7:0])))
    else $error("low count byte wrong");

  c_pulse_done: cover property (capture);
  c_count_read: cover property (count_clear);
  c_timeout: cover property (s.tmo);
endmodule : pwdc_pulse_width_ctrl

//--- tb/pwdc_sync_src.sv
// Behavioural model of the synchronizer that supplies the timing pulse.
// Assumes the bench clock and a one-cycle start request with a width in clocks.
`timescale 1ns/1ps
module pwdc_sync_src #(
  parameter int unsigned MAX_CLK = 16000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [31:0] width_in,
  input wire logic act_high_in,
  output logic pulse_out
);
  int unsigned left;
  // Counts down the active time; widths are capped at MAX_CLK, just above the counter overflow length.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      left <= 0;
    end else if (go_in) begin
      left <= (width_in > MAX_CLK) ? MAX_CLK : width_in;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end
  // The line rests at the inactive level of the chosen polarity.
  assign pulse_out = (left != 0) ? act_high_in : !act_high_in;
endmodule : pwdc_sync_src

//--- tb/testbench.sv
// Self-checking bench of the pulse width delay control block.
// Assumes the design, its package and header, and the synchronizer model.
`timescale 1ns/1ps
`include "pwdc_consts.svh"
module testbench;
  import pwdc_pkg::*;
  localparam int unsigned TK = 3906;
  logic clk_in, rst_in, wr_in, rd_in, pulse_in, lo_j, hi_j, go, act_high;
  logic irq_out, bypass_out, fade_out, mute_out;
  logic [3:0] addr_in, pulse_hyst_in;
  logic [31:0] wr_data_in, rd_data_out, total_delay_out, width, d, lo, hi;
  logic [15:0] base_digits_in, display_out;
  logic [7:0] toggle_sw_in, jumpers_in, frame_hyst_in, panel_out;
  logic [9:0] offset_out;
  wire [10:0] sels;
  int n_errors, checks, k;
  int unsigned seed, base, ea, v;

  pwdc_pulse_width_ctrl #(.TIMEOUT_TICKS(6)) pwdc_pulse_width_ctrl_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .pulse_in(pulse_in),
    .active_low_jumper_in(lo_j), .active_high_jumper_in(hi_j), .base_digits_in(base_digits_in),
    .toggle_sw_in(toggle_sw_in), .jumpers_in(jumpers_in), .frame_hyst_in(frame_hyst_in),
    .pulse_hyst_in(pulse_hyst_in), .irq_out(irq_out), .digit0_select_out(sels[0]),
    .digit1_select_out(sels[1]), .digit2_select_out(sels[2]), .digit3_select_out(sels[3]),
    .panel_led_switch_select_out(sels[4]), .offset_word_select_out(sels[5]),
    .jumper_read_select_out(sels[6]), .frame_hyst_read_select_out(sels[7]),
    .pulse_hyst_read_select_out(sels[8]), .count_read_select_a_out(sels[9]),
    .count_read_select_b_out(sels[10]), .panel_out(panel_out), .offset_out(offset_out),
    .bypass_out(bypass_out), .fade_out(fade_out), .mute_out(mute_out),
    .total_delay_out(total_delay_out), .display_out(display_out)
  );

  pwdc_sync_src pwdc_sync_src_i (
    .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .width_in(width),
    .act_high_in(act_high), .pulse_out(pulse_in)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  // Results that hang on the free-running tick phase may take one of two values.
  task automatic chk2(input logic [31:0] got, input logic [31:0] e0, input logic [31:0] e1);
    checks++;
    if (got !== e0 && got !== e1) begin
      n_errors++;
      $display("Error at %0t: got %08h expected %08h or %08h", $time, got, e0, e1);
    end
  endtask : chk2

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] val);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= val;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] val);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    val = rd_data_out;
  endtask : rd_reg

  // Starts a pulse of w clocks and waits a bounded time for the interrupt.
  task automatic measure(input int unsigned w);
    @(posedge clk_in);
    go <= 1'b1;
    width <= w;
    @(posedge clk_in);
    go <= 1'b0;
    for (int i = 0; i < 12 * TK && irq_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (irq_out !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask : measure

  // Reads the latched count low part first; the high read clears the capture.
  task automatic read_count(output logic [31:0] c);
    wr_reg(`PWDC_A_SEL, 32'h19);
    rd_reg(`PWDC_A_DATA, lo);
    wr_reg(`PWDC_A_SEL, 32'h1A);
    rd_reg(`PWDC_A_DATA, hi);
    chk(hi & 32'hFFFFFFF0, 32'h0);
    c = {20'h0, hi[3:0], lo[7:0]};
  endtask : read_count

  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    seed = 31231;
    {rst_in, wr_in, rd_in, go, lo_j, hi_j, act_high} = 7'b1000011;
    addr_in = 4'h0;
    wr_data_in = 32'h0;
    width = 32'h0;
    base_digits_in = {4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10)};
    {toggle_sw_in, jumpers_in, frame_hyst_in} = 24'(rnd());
    pulse_hyst_in = 4'(rnd() % 10);
    base = base_digits_in[15:12] * 1000 + base_digits_in[11:8] * 100 + base_digits_in[7:4] * 10 + base_digits_in[3:0];
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(`PWDC_A_CTRL, d);
    chk(d, 32'h0);
    rd_reg(4'hF, d);
    chk(d, 32'h0);
    // Every decoder code selects one line; all but the offset code also select a data source.
    for (k = 0; k <= 10; k++) begin
      wr_reg(`PWDC_A_SEL, 32'h10 | k);
      @(posedge clk_in);
      #1;
      chk({21'h0, sels}, 32'h1 << k);
      case (k)
        0, 1, 2, 3: ea = (base_digits_in >> (4 * k)) & 16'hF;
        4: ea = toggle_sw_in;
        6: ea = jumpers_in;
        7: ea = frame_hyst_in;
        8: ea = {1'b0, pulse_hyst_in};
        default: ea = 0;
      endcase
      if (k != 5) begin
        rd_reg(`PWDC_A_DATA, d);
        chk(d, ea);
      end
    end
    wr_reg(`PWDC_A_SEL, 32'h3);
    rd_reg(`PWDC_A_DATA, d);
    chk({21'h0, sels} | d, 32'h0);
    // Offset word follows its staging register once selected; panel lights follow the panel register.
    v = rnd() & 32'h1FFF;
    wr_reg(`PWDC_A_OFS, v);
    wr_reg(`PWDC_A_PANEL, v >> 2);
    wr_reg(`PWDC_A_SEL, 32'h15);
    repeat (3) @(posedge clk_in);
    #1;
    chk({mute_out, fade_out, bypass_out, offset_out}, v);
    chk(panel_out, (v >> 2) & 32'hFF);
    // First pulse is always accepted and sets the compensation.
    pulse_hyst_in <= 4'h9;
    wr_reg(`PWDC_A_CTRL, 32'h1);
    measure(TK * 5 / 2);
    rd_reg(`PWDC_A_STAT, d);
    chk(d & 32'h3, 32'h3);
    read_count(d);
    chk2(d, 2, 3);
    ea = base * 100000 + d * `PWDC_TICK_10NS;
    @(posedge clk_in);
    #1;
    chk(irq_out, 1'b0);
    rd_reg(`PWDC_A_STAT, d);
    chk(d & 32'hF, 32'h0);
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, ea);
    wr_reg(`PWDC_A_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, base * 100000);
    chk(total_delay_out, base * 100000);
    rd_reg(`PWDC_A_DISP, d);
    chk(d, base / `PWDC_FRAME_MS);
    // Millisecond unit shows the base delay itself.
    wr_reg(`PWDC_A_CTRL, 32'h4);
    repeat (2) @(posedge clk_in);
    rd_reg(`PWDC_A_DISP, d);
    chk(d, base);
    chk(display_out, base);
    wr_reg(`PWDC_A_CTRL, 32'h3);
    repeat (2) @(posedge clk_in);
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, 32'h0);
    // A second width inside the widest window leaves the delay alone.
    wr_reg(`PWDC_A_CTRL, 32'h1);
    measure(TK * 9 / 2);
    read_count(d);
    chk2(d, 4, 5);
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, ea);
    // Active-low input held past the timeout forces full compensation.
    @(posedge clk_in);
    {rst_in, act_high, lo_j, hi_j} <= 4'b1010;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    wr_reg(`PWDC_A_CTRL, 32'h1);
    @(posedge clk_in);
    go <= 1'b1;
    width <= TK * 17 / 2;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (TK * 7) @(posedge clk_in);
    rd_reg(`PWDC_A_STAT, d);
    chk((d >> 4) & 32'h1, 32'h1);
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, base * 100000 + 4095 * 1953);
    // A zero-width request cuts the held pulse; the far-off width is accepted.
    measure(0);
    read_count(d);
    chk2(d, 7, 8);
    ea = base * 100000 + d * `PWDC_TICK_10NS;
    rd_reg(`PWDC_A_TOTAL, d);
    chk(d, ea);
    finish_test();
  end
endmodule : testbench
